// ### common/dsuc_defines.vh
// constants for the dual dac serial update control block
//
// How it works
// - each of the first 24 falling serial clock edges inside an open frame shifts one data bit into the 24-bit shift register.
// - the host opens a frame by pulling frame select low, and only then are the following falling edges sampled.
// - if frame select rises before the 24th edge, the partial word is dropped and no buffer or dac register changes.
// - with the load strobe held low, the dac outputs update on the 24th falling edge after the frame opens.
// - with the load strobe high, a falling edge on it moves both channel buffers into both dac registers at once.
// - a falling edge on the clear input loads zero or mid scale, per variant, into every buffer and dac register.
// - after a clear the block stays in clear-code mode until the 24th falling edge of the next frame ends it.
// - a clear that arrives during a frame aborts that write and none of its bits are used.

`ifndef DSUC_DEFINES_VH
`define DSUC_DEFINES_VH

// serial word
`define DSUC_WORD_BITS 24
`define DSUC_CNT_W 5
`define DSUC_CNT_ZERO 5'h00
`define DSUC_CNT_LAST 5'h17
`define DSUC_CNT_INTR 5'h16

// word layout
`define DSUC_DATA_W 16
`define DSUC_DATA_HI 15
`define DSUC_SEL_A_BIT 16
`define DSUC_SEL_B_BIT 17

// clear codes
`define DSUC_ZERO_CODE 16'h0000
`define DSUC_MID_CODE 16'h8000

// input synchroniser
`define DSUC_IN_W 5
`define DSUC_IN_RST 5'h1f
`define DSUC_IN_SCLK 0
`define DSUC_IN_FRAME 1
`define DSUC_IN_LOAD 2
`define DSUC_IN_CLEAR 3
`define DSUC_IN_DATA 4

// host serial clock limit
`define DSUC_SCLK_MAX_MHZ 50

// frame states
`define DSUC_ST_W 2
`define DSUC_ST_IDLE 2'h0
`define DSUC_ST_SHIFT 2'h1
`define DSUC_ST_DONE 2'h2

`endif

// ### rtl/dsuc_sync.v
// two-stage synchroniser for the serial, update and clear pins
`timescale 1ns/1ns
module dsuc_sync #(
    parameter WIDTH = 5,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // pins
    input wire [WIDTH-1:0] pin_in,
    // synchronised levels
    output wire [WIDTH-1:0] pin_s
);

reg [WIDTH-1:0] meta_r;
reg [WIDTH-1:0] sync_r;

genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
        always @(posedge mclk) begin
            if (rst) begin
                meta_r[i] <= RST_VAL[i];
                sync_r[i] <= RST_VAL[i];
            end else begin
                meta_r[i] <= pin_in[i];
                sync_r[i] <= meta_r[i];
            end
        end
    end
endgenerate

assign pin_s = sync_r;

endmodule // dsuc_sync

// ### rtl/dsuc_top.v
// serial write front end and update control of a dual dac
`timescale 1ns/1ns
`include "dsuc_defines.vh"

module dsuc_top #(
    parameter CLEAR_TO_MID = 0
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // serial pins
    input wire sclk,
    input wire frame_n,
    input wire sdin,
    // update and clear pins
    input wire load_strobe_n,
    input wire async_clear_n,
    // last complete word
    output reg [`DSUC_WORD_BITS-1:0] word_r,
    output reg word_valid_r,
    // channel buffers
    output reg [`DSUC_DATA_W-1:0] buf_a_r,
    output reg [`DSUC_DATA_W-1:0] buf_b_r,
    // dac registers
    output reg [`DSUC_DATA_W-1:0] dac_a_r,
    output reg [`DSUC_DATA_W-1:0] dac_b_r,
    output reg dac_update_r,
    // status
    output reg clear_mode_r,
    output reg frame_abort_r,
    output wire frame_busy
);

// ----------------------------------------
// clear code
// ----------------------------------------
localparam [`DSUC_DATA_W-1:0] CLEAR_CODE = CLEAR_TO_MID ? `DSUC_MID_CODE : `DSUC_ZERO_CODE;

localparam [`DSUC_ST_W-1:0] ST_IDLE = `DSUC_ST_IDLE;
localparam [`DSUC_ST_W-1:0] ST_SHIFT = `DSUC_ST_SHIFT;
localparam [`DSUC_ST_W-1:0] ST_DONE = `DSUC_ST_DONE;

// ----------------------------------------
// input synchronisers
// ----------------------------------------
wire [`DSUC_IN_W-1:0] pin_s;

dsuc_sync #(
    .WIDTH(`DSUC_IN_W),
    .RST_VAL(`DSUC_IN_RST)
) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in({sdin, async_clear_n, load_strobe_n, frame_n, sclk}),
    .pin_s(pin_s)
);

wire sclk_s = pin_s[`DSUC_IN_SCLK];
wire frame_n_s = pin_s[`DSUC_IN_FRAME];
wire load_n_s = pin_s[`DSUC_IN_LOAD];
wire clear_n_s = pin_s[`DSUC_IN_CLEAR];
wire sdin_s = pin_s[`DSUC_IN_DATA];

// ----------------------------------------
// edge detection
// ----------------------------------------
reg sclk_d_r;
reg frame_n_d_r;
reg load_n_d_r;
reg clear_n_d_r;

always @(posedge mclk) begin
    if (rst) begin
        sclk_d_r <= 1'b1;
        frame_n_d_r <= 1'b1;
        load_n_d_r <= 1'b1;
        clear_n_d_r <= 1'b1;
    end else begin
        sclk_d_r <= sclk_s;
        frame_n_d_r <= frame_n_s;
        load_n_d_r <= load_n_s;
        clear_n_d_r <= clear_n_s;
    end
end

wire sclk_fall = sclk_d_r & ~sclk_s;
wire frame_fall = frame_n_d_r & ~frame_n_s;
wire frame_rise = ~frame_n_d_r & frame_n_s;
wire load_fall = load_n_d_r & ~load_n_s;
wire clear_fall = clear_n_d_r & ~clear_n_s;

// ----------------------------------------
// frame state and shift register
// ----------------------------------------
reg [`DSUC_ST_W-1:0] state_r;
reg [`DSUC_ST_W-1:0] state_nxt;
reg [`DSUC_CNT_W-1:0] cnt_r;
reg [`DSUC_CNT_W-1:0] cnt_nxt;
reg [`DSUC_WORD_BITS-1:0] shift_r;
reg [`DSUC_WORD_BITS-1:0] shift_nxt;
reg word_done;
reg abort;

wire [`DSUC_WORD_BITS-1:0] shift_in = {shift_r[`DSUC_WORD_BITS-2:0], sdin_s};

always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    word_done = 1'b0;
    abort = 1'b0;
    case (state_r)
        ST_IDLE: begin
            if (frame_fall && !clear_fall) begin
                state_nxt = ST_SHIFT;
                cnt_nxt = `DSUC_CNT_ZERO;
            end
        end
        ST_SHIFT: begin
            if (clear_fall) begin
                state_nxt = ST_IDLE;
                abort = 1'b1;
            end else if (frame_rise) begin
                state_nxt = ST_IDLE;
                abort = 1'b1;
            end else if (sclk_fall) begin
                shift_nxt = shift_in;
                if (cnt_r == `DSUC_CNT_LAST) begin
                    state_nxt = ST_DONE;
                    word_done = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
        end
        ST_DONE: begin
            if (frame_rise) begin
                state_nxt = ST_IDLE;
            end
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge mclk) begin
    if (rst) begin
        state_r <= ST_IDLE;
        cnt_r <= `DSUC_CNT_ZERO;
        shift_r <= {`DSUC_WORD_BITS{1'b0}};
    end else begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        shift_r <= shift_nxt;
    end
end

assign frame_busy = (state_r == ST_SHIFT);

// ----------------------------------------
// channel buffers and dac registers
// ----------------------------------------
wire sel_a = shift_in[`DSUC_SEL_A_BIT];
wire sel_b = shift_in[`DSUC_SEL_B_BIT];
wire [`DSUC_DATA_W-1:0] word_data = shift_in[`DSUC_DATA_HI:0];

reg [`DSUC_DATA_W-1:0] buf_a_nxt;
reg [`DSUC_DATA_W-1:0] buf_b_nxt;
reg [`DSUC_DATA_W-1:0] dac_a_nxt;
reg [`DSUC_DATA_W-1:0] dac_b_nxt;
reg update_nxt;

always @* begin
    buf_a_nxt = buf_a_r;
    buf_b_nxt = buf_b_r;
    dac_a_nxt = dac_a_r;
    dac_b_nxt = dac_b_r;
    update_nxt = 1'b0;
    if (clear_fall) begin
        buf_a_nxt = CLEAR_CODE;
        buf_b_nxt = CLEAR_CODE;
        dac_a_nxt = CLEAR_CODE;
        dac_b_nxt = CLEAR_CODE;
        update_nxt = 1'b1;
    end else begin
        if (word_done) begin
            if (sel_a) begin
                buf_a_nxt = word_data;
            end
            if (sel_b) begin
                buf_b_nxt = word_data;
            end
            if (!load_n_s) begin
                dac_a_nxt = buf_a_nxt;
                dac_b_nxt = buf_b_nxt;
                update_nxt = 1'b1;
            end
        end
        if (load_fall) begin
            dac_a_nxt = buf_a_nxt;
            dac_b_nxt = buf_b_nxt;
            update_nxt = 1'b1;
        end
    end
end

always @(posedge mclk) begin
    if (rst) begin
        buf_a_r <= CLEAR_CODE;
        buf_b_r <= CLEAR_CODE;
        dac_a_r <= CLEAR_CODE;
        dac_b_r <= CLEAR_CODE;
        dac_update_r <= 1'b0;
    end else begin
        buf_a_r <= buf_a_nxt;
        buf_b_r <= buf_b_nxt;
        dac_a_r <= dac_a_nxt;
        dac_b_r <= dac_b_nxt;
        dac_update_r <= update_nxt;
    end
end

// ----------------------------------------
// word capture and status
// ----------------------------------------
always @(posedge mclk) begin
    if (rst) begin
        word_r <= {`DSUC_WORD_BITS{1'b0}};
        word_valid_r <= 1'b0;
        clear_mode_r <= 1'b0;
        frame_abort_r <= 1'b0;
    end else begin
        word_valid_r <= word_done;
        frame_abort_r <= abort;
        if (word_done) begin
            word_r <= shift_in;
        end
        if (clear_fall) begin
            clear_mode_r <= 1'b1;
        end else if (word_done) begin
            clear_mode_r <= 1'b0;
        end
    end
end

endmodule // dsuc_top

// ### testbench/dsuc_host_model.sv
// host model driving the serial write link
`timescale 1ns/1ns
module dsuc_host_model (
    // clock
    input wire mclk,
    // serial link
    output logic sclk,
    output logic frame_n,
    output logic sdin
);
    initial begin
        sclk = 1'b1;
        frame_n = 1'b1;
        sdin = 1'b0;
    end
    task automatic tick(input int c);
        repeat (c) @(negedge mclk);
    endtask
    // n word bits, then x extra edges in the same frame; 160 ns period
    task automatic send(input logic [23:0] w, input int n, input int x);
        frame_n = 1'b0;
        tick(4);
        for (int i = 0; i < n + x; i++) begin
            sdin = (i < 24) ? w[23-i] : ~sdin;
            tick(4);
            sclk = 1'b0;
            tick(4);
            sclk = 1'b1;
        end
        tick(4);
        frame_n = 1'b1;
        sdin = ~sdin;
        tick(8);
    endtask
endmodule // dsuc_host_model

// ### testbench/dsuc_tb_assertions.sv
// port assertions for the dual dac update control
`timescale 1ns/1ns
module dsuc_tb_assertions #(
    parameter CLEAR_TO_MID = 0
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // watched ports
    input wire frame_n,
    input wire word_valid_r,
    input wire [15:0] buf_a_r,
    input wire [15:0] dac_a_r,
    input wire [15:0] dac_b_r,
    input wire dac_update_r,
    input wire clear_mode_r,
    input wire frame_abort_r,
    input wire frame_busy
);
    localparam [15:0] CODE = CLEAR_TO_MID ? 16'h8000 : 16'h0000;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_word_pulse: assert property (word_valid_r |=> !word_valid_r)
        else $error("word pulse too long");
    a_busy_frame: assert property ($rose(frame_busy) |-> !frame_n)
        else $error("busy without frame");
    a_abort_clean: assert property (frame_abort_r |-> !word_valid_r && !frame_busy)
        else $error("aborted frame completed");
    a_dac_moves: assert property (!$stable(dac_a_r) || !$stable(dac_b_r) |-> dac_update_r)
        else $error("dac changed without update");
    a_update_pulse: assert property (dac_update_r |=> !dac_update_r)
        else $error("update pulse too long");
    a_clear_load: assert property ($rose(clear_mode_r) |-> dac_update_r && dac_a_r == CODE && dac_b_r == CODE
        && buf_a_r == CODE)
        else $error("clear code not loaded");
    a_clear_exit: assert property (word_valid_r |-> !clear_mode_r)
        else $error("clear mode kept");
    a_done_idle: assert property (word_valid_r |-> !frame_busy ##1 !frame_busy)
        else $error("edges taken after word");
    a_abort_pulse: assert property (frame_abort_r |=> !frame_abort_r)
        else $error("abort pulse too long");
endmodule // dsuc_tb_assertions

// ### testbench/tb_top.sv
// self-checking bench for the dual dac update control
`timescale 1ns/1ns
module tb_top;
    localparam logic [15:0] CODE = 16'h8000;
    logic mclk, rst, sclk, frame_n, sdin, ld_n, clr_n, em;
    logic word_valid_r, dac_update_r, clear_mode_r, frame_abort_r, frame_busy;
    logic [23:0] word_r, ew, w;
    logic [15:0] buf_a_r, buf_b_r, dac_a_r, dac_b_r, ea, eb, da, db;
    int fails = 0, num_checks = 0, nvalid = 0, evalid = 0, r;
    int nabort = 0, eabort = 0, nupd = 0, eupd = 0;
    dsuc_top #(.CLEAR_TO_MID(1)) uut (.mclk(mclk), .rst(rst), .sclk(sclk), .frame_n(frame_n), .sdin(sdin),
        .load_strobe_n(ld_n), .async_clear_n(clr_n), .word_r(word_r), .word_valid_r(word_valid_r),
        .buf_a_r(buf_a_r), .buf_b_r(buf_b_r), .dac_a_r(dac_a_r), .dac_b_r(dac_b_r),
        .dac_update_r(dac_update_r), .clear_mode_r(clear_mode_r), .frame_abort_r(frame_abort_r),
        .frame_busy(frame_busy));
    dsuc_host_model host (.mclk(mclk), .sclk(sclk), .frame_n(frame_n), .sdin(sdin));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (word_valid_r === 1'b1) nvalid++;
    always @(posedge mclk) if (frame_abort_r === 1'b1) nabort++;
    always @(posedge mclk) if (dac_update_r === 1'b1) nupd++;
    task automatic give_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic check_all();
        chk(word_r, ew);
        chk(24'(buf_a_r), 24'(ea));
        chk(24'(buf_b_r), 24'(eb));
        chk(24'(dac_a_r), 24'(da));
        chk(24'(dac_b_r), 24'(db));
        chk(24'(clear_mode_r), 24'(em));
        chk(24'(frame_busy), 24'h00_0000);
    endtask
    task automatic set_ld(input logic v);
        if (ld_n && !v) begin
            da = ea;
            db = eb;
            eupd++;
        end
        ld_n = v;
        repeat (8) @(negedge mclk);
    endtask
    task automatic clear();
        clr_n = 1'b0;
        ea = CODE;
        eb = CODE;
        da = CODE;
        db = CODE;
        em = 1'b1;
        eupd++;
        repeat (4) @(negedge mclk);
        clr_n = 1'b1;
        repeat (8) @(negedge mclk);
    endtask
    task automatic frame(input int n, input int x);
        w = 24'($urandom);
        host.send(w, n, x);
        if (n < 24) begin
            eabort++;
        end
        if (n >= 24) begin
            ew = w;
            evalid++;
            em = 1'b0;
            if (w[16]) ea = w[15:0];
            if (w[17]) eb = w[15:0];
            if (!ld_n) begin
                da = ea;
                db = eb;
                eupd++;
            end
        end
    endtask
    initial begin
        r = $urandom(66499);
        rst = 1'b1;
        ld_n = 1'b1;
        clr_n = 1'b1;
        {ea, eb, da, db, ew, em} = {CODE, CODE, CODE, CODE, 24'h00_0000, 1'b0};
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        check_all();
        frame(24, 24);
        check_all();
        clear();
        set_ld(1'b1);
        frame(24, 0);
        frame(24, 0);
        set_ld(1'b0);
        check_all();
        for (int i = 0; i < 40; i++) begin
            case ($urandom % 5)
                0: frame(24, 0);
                1: frame(1 + $urandom % 22, 0);
                2: set_ld(~ld_n);
                3: clear();
                default: fork
                    host.send(24'($urandom), 24, 0);
                    begin
                        repeat (60) @(negedge mclk);
                        chk(24'(frame_busy), 24'h00_0001);
                        eabort++;
                        clear();
                    end
                join
            endcase
            check_all();
        end
        chk(24'(nvalid), 24'(evalid));
        chk(24'(nabort), 24'(eabort));
        chk(24'(nupd), 24'(eupd));
        give_verdict();
    end
    initial begin
        // about 50 frames of 210 cycles each take some 10,500 cycles; this span is 50,000
        #1000000;
        fails++;
        give_verdict();
    end
endmodule // tb_top
bind dsuc_top dsuc_tb_assertions #(.CLEAR_TO_MID(CLEAR_TO_MID)) chk_i (.mclk(mclk), .rst(rst),
    .frame_n(frame_n), .word_valid_r(word_valid_r), .buf_a_r(buf_a_r), .dac_a_r(dac_a_r), .dac_b_r(dac_b_r),
    .dac_update_r(dac_update_r), .clear_mode_r(clear_mode_r), .frame_abort_r(frame_abort_r),
    .frame_busy(frame_busy));
